// [core/ardc_pkg.sv]
// Purpose: Shared constants and types for the converter rate divider
// Assumes: sys_clk is the master clock, 100 MHz
// Notes:   Register offsets are byte addresses of 32-bit words
package ardc_pkg;

  localparam int ARDC_CHANNELS   = 3;
  localparam int ARDC_WORD_W     = 24;
  localparam int ARDC_GAIN_FRAC  = 23;

  typedef logic [23:0] ardc_word_t;

  typedef struct packed {
    logic [1:0] prescale;
    logic [2:0] osr;
  } ardc_config_t;

  // Field positions in the primary configuration word
  localparam int ARDC_CFG_PRESCALE_LSB = 0;
  localparam int ARDC_CFG_OSR_LSB      = 4;

  // Reset values
  localparam logic [1:0] ARDC_PRESCALE_RST = 2'h0;
  localparam logic [2:0] ARDC_OSR_RST      = 3'h3;
  localparam ardc_word_t ARDC_CAL_RST      = 24'h000000;
  localparam logic [1:0] ARDC_IRQ_RST      = 2'h0;

  // Timing: ratio 32 at the lowest code, sampling is prescaled clock over four
  localparam logic [12:0] ARDC_OSR_BASE     = 13'h0020;
  localparam logic [1:0]  ARDC_SAMPLE_LAST  = 2'h3;
  localparam logic [19:0] ARDC_RATE_BASE    = 20'h00080;
  localparam logic [4:0]  ARDC_SCALE_TOP    = 5'h12;

  // Interrupt status bits
  localparam int ARDC_IRQ_READY   = 0;
  localparam int ARDC_IRQ_OVERRUN = 1;

  // Register offsets
  localparam logic [7:0] ARDC_REG_CONFIG  = 8'h00;
  localparam logic [7:0] ARDC_REG_OFFSET0 = 8'h04;
  localparam logic [7:0] ARDC_REG_OFFSET1 = 8'h08;
  localparam logic [7:0] ARDC_REG_OFFSET2 = 8'h0c;
  localparam logic [7:0] ARDC_REG_GAIN0   = 8'h10;
  localparam logic [7:0] ARDC_REG_GAIN1   = 8'h14;
  localparam logic [7:0] ARDC_REG_GAIN2   = 8'h18;
  localparam logic [7:0] ARDC_REG_STATUS  = 8'h1c;
  localparam logic [7:0] ARDC_REG_MASK    = 8'h20;
  localparam logic [7:0] ARDC_REG_RESULT0 = 8'h24;
  localparam logic [7:0] ARDC_REG_RESULT1 = 8'h28;
  localparam logic [7:0] ARDC_REG_RESULT2 = 8'h2c;

  localparam logic signed [26:0] ARDC_SAT_MAX = 27'sh07fffff;
  localparam logic signed [26:0] ARDC_SAT_MIN = -27'sh0800000;

endpackage : ardc_pkg

// [core/ardc_top.sv]
// Purpose: Prescaler, sampling divider, sinc decimator and calibration
// Assumes: modulator_bits sampled on sampling ticks, 1 means +1, 0 means -1
// Notes:   Ready set wins over read-clear, read-clear wins over overrun set; a config write restarts the chain
// Function
// - Three-bit ratio code decodes as 32 doubling up to 4096.
// - Ratio code resets to the value selecting 256.
// - One result per channel every ratio sampling periods.
// - Output rate is master clock over four times ratio times prescale.
// - Decimator is a sinc filter, zeros at multiples of output rate.
// - Each channel adds its own 24-bit offset correction word.
// - Each channel scales by its own 24-bit gain correction word.
// - Two-bit prescaler divides master clock by 1, 2, 4, 8; default 1.
// - Sampling clock is prescaled clock divided by four.
// - Each new result is flagged by a data ready pulse.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ardc_top (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic [2:0]               modulator_bits,
  output logic                          analog_prescaled_clock,
  output logic                          sampling_clock,
  output logic                          data_ready_output,
  output ardc_pkg::ardc_word_t [2:0]    channel_results,
  output logic                          irq
);

  ardc_pkg::ardc_config_t primary_configuration;
  ardc_pkg::ardc_word_t   channel_offset_correction [3];
  ardc_pkg::ardc_word_t   channel_gain_correction [3];
  logic [1:0]             irq_status;
  logic [1:0]             irq_mask;
  logic                   cfg_wr;
  logic                   status_rd;
  logic [31:0]            next_rdata;
  logic [2:0]             pre_cnt;
  logic [2:0]             pre_last;
  logic                   prescale_tick;
  logic [1:0]             quarter_cnt;
  logic                   sample_tick;
  logic [11:0]            dec_cnt;
  logic [11:0]            dec_last;
  logic                   dump;
  logic signed [13:0]     acc [3];
  logic signed [13:0]     dump_sum [3];
  logic                   dump_valid;
  logic signed [23:0]     stage1 [3];
  logic                   stage1_valid;
  logic signed [26:0]     scaled [3];
  assign cfg_wr    = reg_wr && (reg_addr == ardc_pkg::ARDC_REG_CONFIG);
  assign status_rd = reg_rd && (reg_addr == ardc_pkg::ARDC_REG_STATUS);

  function automatic logic signed [23:0] sat24(input logic signed [26:0] v);
    if (v > ardc_pkg::ARDC_SAT_MAX)
      return ardc_pkg::ARDC_SAT_MAX[23:0];
    else if (v < ardc_pkg::ARDC_SAT_MIN)
      return ardc_pkg::ARDC_SAT_MIN[23:0];
    else
      return v[23:0];
  endfunction : sat24

  // Register writes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      primary_configuration.osr      <= ardc_pkg::ARDC_OSR_RST;
      primary_configuration.prescale <= ardc_pkg::ARDC_PRESCALE_RST;
      irq_mask                       <= ardc_pkg::ARDC_IRQ_RST;
      for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
      begin
        channel_offset_correction[i] <= ardc_pkg::ARDC_CAL_RST;
        channel_gain_correction[i]   <= ardc_pkg::ARDC_CAL_RST;
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == ardc_pkg::ARDC_REG_CONFIG)
      begin
        primary_configuration.prescale <= reg_wdata[ardc_pkg::ARDC_CFG_PRESCALE_LSB +: 2];
        primary_configuration.osr      <= reg_wdata[ardc_pkg::ARDC_CFG_OSR_LSB +: 3];
      end
      else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET0)
        channel_offset_correction[0] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET1)
        channel_offset_correction[1] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET2)
        channel_offset_correction[2] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_GAIN0)
        channel_gain_correction[0] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_GAIN1)
        channel_gain_correction[1] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_GAIN2)
        channel_gain_correction[2] <= reg_wdata[23:0];
      else if (reg_addr == ardc_pkg::ARDC_REG_MASK)
        irq_mask <= reg_wdata[1:0];
    end
  end

  // Read mux, unmapped reads return zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_addr == ardc_pkg::ARDC_REG_CONFIG)
      next_rdata = {25'h0, primary_configuration.osr, 2'h0,
                    primary_configuration.prescale};
    else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET0)
      next_rdata = {8'h00, channel_offset_correction[0]};
    else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET1)
      next_rdata = {8'h00, channel_offset_correction[1]};
    else if (reg_addr == ardc_pkg::ARDC_REG_OFFSET2)
      next_rdata = {8'h00, channel_offset_correction[2]};
    else if (reg_addr == ardc_pkg::ARDC_REG_GAIN0)
      next_rdata = {8'h00, channel_gain_correction[0]};
    else if (reg_addr == ardc_pkg::ARDC_REG_GAIN1)
      next_rdata = {8'h00, channel_gain_correction[1]};
    else if (reg_addr == ardc_pkg::ARDC_REG_GAIN2)
      next_rdata = {8'h00, channel_gain_correction[2]};
    else if (reg_addr == ardc_pkg::ARDC_REG_STATUS)
      next_rdata = {30'h0, irq_status};
    else if (reg_addr == ardc_pkg::ARDC_REG_MASK)
      next_rdata = {30'h0, irq_mask};
    else if (reg_addr == ardc_pkg::ARDC_REG_RESULT0)
      next_rdata = {8'h00, channel_results[0]};
    else if (reg_addr == ardc_pkg::ARDC_REG_RESULT1)
      next_rdata = {8'h00, channel_results[1]};
    else if (reg_addr == ardc_pkg::ARDC_REG_RESULT2)
      next_rdata = {8'h00, channel_results[2]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

  assign pre_last   = 3'((4'h1 << primary_configuration.prescale) - 4'h1);
  assign prescale_tick = (pre_cnt == pre_last);
  assign sample_tick = prescale_tick && (quarter_cnt == ardc_pkg::ARDC_SAMPLE_LAST);
  assign dec_last = 12'((ardc_pkg::ARDC_OSR_BASE << primary_configuration.osr) - 13'h0001);
  assign dump     = sample_tick && (dec_cnt == dec_last);

  // shared counters
  // A config write restarts the chain so the first result is never mixed
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cfg_wr)
    begin
      pre_cnt     <= 3'h0;
      quarter_cnt <= 2'h0;
      dec_cnt     <= 12'h000;
    end
    else
    begin
      pre_cnt <= prescale_tick ? 3'h0 : pre_cnt + 3'h1;
      if (prescale_tick)
        quarter_cnt <= quarter_cnt + 2'h1;
      if (sample_tick)
        dec_cnt <= dump ? 12'h000 : dec_cnt + 12'h001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      analog_prescaled_clock <= 1'b0;
      sampling_clock         <= 1'b0;
    end
    else
    begin
      analog_prescaled_clock <= prescale_tick && !cfg_wr;
      sampling_clock         <= sample_tick && !cfg_wr;
    end
  end

  // sinc accumulate and dump
  // Boxcar over the ratio window puts a zero at every multiple of the rate
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cfg_wr)
    begin
      dump_valid <= 1'b0;
      for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
      begin
        acc[i]      <= 14'sh0000;
        dump_sum[i] <= 14'sh0000;
      end
    end
    else
    begin
      dump_valid <= dump;
      for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
      begin
        if (dump)
        begin
          acc[i]      <= 14'sh0000;
          dump_sum[i] <= acc[i] + (modulator_bits[i] ? 14'sh0001 : -14'sh0001);
        end
        else if (sample_tick)
          acc[i] <= acc[i] + (modulator_bits[i] ? 14'sh0001 : -14'sh0001);
      end
    end
  end

  // Full-scale sum maps to the 24-bit full scale for every ratio
  always_comb
  begin
    for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
      scaled[i] = 27'(dump_sum[i]) <<< (ardc_pkg::ARDC_SCALE_TOP - 5'(primary_configuration.osr));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cfg_wr)
    begin
      stage1_valid <= 1'b0;
      for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
        stage1[i] <= 24'sh000000;
    end
    else
    begin
      stage1_valid <= dump_valid;
      if (dump_valid)
        for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
          stage1[i] <= sat24(scaled[i] + 27'($signed(channel_offset_correction[i])));
    end
  end

  // gain correction, word is a signed fraction added to a gain of one
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      data_ready_output <= 1'b0;
      channel_results   <= '0;
    end
    else
    begin
      data_ready_output <= stage1_valid && !cfg_wr;
      if (stage1_valid && !cfg_wr)
        for (int i = 0; i < ardc_pkg::ARDC_CHANNELS; i++)
          channel_results[i] <= sat24(27'(stage1[i])
            + 27'(48'(stage1[i] * $signed(channel_gain_correction[i]))
            >>> ardc_pkg::ARDC_GAIN_FRAC));
    end
  end

  // Sticky status; a new ready event wins over the read that clears, the read wins over a new overrun
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irq_status <= ardc_pkg::ARDC_IRQ_RST;
    else
    begin
      irq_status <= (status_rd ? 2'h0 : irq_status)
        | {data_ready_output && irq_status[ardc_pkg::ARDC_IRQ_READY] && !status_rd,
           data_ready_output};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // Helper counters for checks
  logic [19:0] ready_gap;
  logic        ready_gap_ok;
  logic [19:0] rate_period;
  logic [5:0]  smp_gap;
  logic        smp_gap_ok;
  logic [5:0]  smp_period;
  assign rate_period = (ardc_pkg::ARDC_RATE_BASE << primary_configuration.prescale)
                       << primary_configuration.osr;
  // Six bits, so divide by 32 does not wrap to zero
  assign smp_period  = ({4'h0, ardc_pkg::ARDC_SAMPLE_LAST} + 6'h01)
                       << primary_configuration.prescale;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cfg_wr)
    begin
      ready_gap    <= 20'h00000;
      ready_gap_ok <= 1'b0;
      smp_gap      <= 6'h00;
      smp_gap_ok   <= 1'b0;
    end
    else
    begin
      ready_gap    <= data_ready_output ? 20'h00001 : ready_gap + 20'h00001;
      ready_gap_ok <= ready_gap_ok || data_ready_output;
      smp_gap      <= sampling_clock ? 6'h01 : smp_gap + 6'h01;
      smp_gap_ok   <= smp_gap_ok || sampling_clock;
    end
  end

  property p_osr_reset;
    @(posedge sys_clk) $rose(rst_n) |-> primary_configuration.osr == ardc_pkg::ARDC_OSR_RST;
  endproperty
  a_osr_reset: assert property (p_osr_reset) else $error("ratio code not 256 at reset");
  property p_pre_reset;
    @(posedge sys_clk)
      $rose(rst_n) |-> primary_configuration.prescale == ardc_pkg::ARDC_PRESCALE_RST;
  endproperty
  a_pre_reset: assert property (p_pre_reset) else $error("prescale not 1 at reset");
  property p_sample_period;
    @(posedge sys_clk) disable iff (!rst_n)
      sampling_clock && smp_gap_ok && !$past(cfg_wr)
      |-> smp_gap == smp_period;
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("sampling period wrong");
  property p_rate_period;
    @(posedge sys_clk) disable iff (!rst_n)
      data_ready_output && ready_gap_ok |-> ready_gap == rate_period;
  endproperty
  a_rate_period: assert property (p_rate_period) else $error("output rate period wrong");
  property p_ready_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      data_ready_output |=> !data_ready_output;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("data ready too wide");
  property p_dump_to_ready;
    @(posedge sys_clk) disable iff (!rst_n)
      dump && !cfg_wr ##1 !cfg_wr ##1 !cfg_wr |=> data_ready_output;
  endproperty
  a_dump_to_ready: assert property (p_dump_to_ready) else $error("result not flagged");
  property p_offset;
    @(posedge sys_clk) disable iff (!rst_n || cfg_wr)
      dump_valid |=> stage1[1] == sat24($past(scaled[1])
        + 27'($signed($past(channel_offset_correction[1]))));
  endproperty
  a_offset: assert property (p_offset) else $error("offset correction wrong");
  property p_unity_gain;
    @(posedge sys_clk) disable iff (!rst_n || cfg_wr)
      stage1_valid && channel_gain_correction[2] == 24'h000000
      |=> channel_results[2] == $past(stage1[2]);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("zero gain word changed result");
  property p_irq_ready;
    @(posedge sys_clk) disable iff (!rst_n)
      data_ready_output && irq_mask[0] && !reg_wr ##1 !reg_wr |=> irq;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("ready interrupt missing");
  c_ready:    cover property (@(posedge sys_clk) disable iff (!rst_n) data_ready_output);
  c_max_osr:  cover property (@(posedge sys_clk) disable iff (!rst_n)
                data_ready_output && primary_configuration.osr == 3'h7);
  c_overrun:  cover property (@(posedge sys_clk) disable iff (!rst_n) irq_status[1]);
  c_prescale: cover property (@(posedge sys_clk) disable iff (!rst_n)
                sampling_clock && primary_configuration.prescale == 2'h3);
endmodule : ardc_top

// [dv/ardc_top_tb.sv]
// Purpose: Self-checking bench for the rate divider and calibration block
// Assumes: Constant modulator bits, so every window sums to full scale
// Notes:   Periods timed between pulses; window cut by a restart not timed
`timescale 1ns/1ps
module ardc_top_tb;
  logic                           sys_clk;
  logic                           rst_n;
  logic [7:0]                     reg_addr;
  logic [31:0]                    reg_wdata;
  logic                           reg_wr;
  logic                           reg_rd;
  logic [31:0]                    reg_rdata;
  logic [2:0]                     modulator_bits;
  logic                           analog_prescaled_clock;
  logic                           sampling_clock;
  logic                           data_ready_output;
  ardc_pkg::ardc_word_t [2:0]     channel_results;
  logic                           irq;
  int unsigned                    miscompares;
  int unsigned                    samples_checked;
  int unsigned                    cycles;
  int                             n;
  logic [31:0]                    rdat;
  // Sweep up to ratio 4096 needs about 75k cycles
  localparam int TIMEOUT_CYCLES = 90000;

  ardc_top u_dut (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .modulator_bits         (modulator_bits),
    .analog_prescaled_clock (analog_prescaled_clock),
    .sampling_clock         (sampling_clock),
    .data_ready_output      (data_ready_output),
    .channel_results        (channel_results),
    .irq                    (irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == TIMEOUT_CYCLES)
    begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked = samples_checked + 1;
    if (seen !== expected)
    begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  function automatic logic pick(input int which);
    case (which)
      0:       pick = analog_prescaled_clock;
      1:       pick = sampling_clock;
      default: pick = data_ready_output;
    endcase
  endfunction : pick

  // Bounded so a dead pulse cannot hang the run
  task automatic wait_pulse(input int which, output int cnt);
    cnt = 1;
    tick();
    while (pick(which) !== 1'b1 && cnt < 40000)
    begin
      tick();
      cnt++;
    end
  endtask : wait_pulse

  task automatic measure(input int which, input logic [31:0] expected);
    int c;
    wait_pulse(which, c);
    wait_pulse(which, c);
    check(32'(c), expected);
  endtask : measure

  initial
  begin
    miscompares     = 0;
    samples_checked = 0;
    cycles          = 0;
    rst_n           = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    // Ch0 +1, ch1 -1, ch2 +1
    modulator_bits  = 3'h5;
    repeat (11) @(posedge sys_clk);
    #1;
    check({28'h0, irq, data_ready_output, sampling_clock, analog_prescaled_clock}, 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4)
    begin
      rd(8'(a), rdat);
      check(rdat, (a == 0) ? 32'h30 : 32'h0);
    end
    // Unmapped place ignores writes
    wr(8'h40, 32'hffffffff);
    rd(8'h40, rdat);
    check(rdat, 32'h0);
    rd(ardc_pkg::ARDC_REG_CONFIG, rdat);
    check(rdat, 32'h30);
    measure(2, 32'd1024);
    for (int p = 0; p < 4; p++)
    begin
      wr(ardc_pkg::ARDC_REG_CONFIG, 32'(p));
      measure(0, 32'h1 << p);
      measure(1, 32'h4 << p);
      measure(2, 32'h80 << p);
    end
    for (int o = 1; o < 8; o++)
    begin
      wr(ardc_pkg::ARDC_REG_CONFIG, 32'(o) << 4);
      measure(2, 32'h80 << o);
    end
    wr(ardc_pkg::ARDC_REG_CONFIG, 32'h0);
    wr(ardc_pkg::ARDC_REG_OFFSET1, 32'h00100000);
    wr(ardc_pkg::ARDC_REG_OFFSET2, 32'hffc00000);
    wr(ardc_pkg::ARDC_REG_GAIN2, 32'h00400000);
    rd(ardc_pkg::ARDC_REG_OFFSET2, rdat);
    check(rdat, 32'h00c00000);
    rd(ardc_pkg::ARDC_REG_GAIN2, rdat);
    check(rdat, 32'h00400000);
    // Second pulse sees the new words over a whole window
    wait_pulse(2, n);
    wait_pulse(2, n);
    check({8'h0, channel_results[0]}, 32'h007fffff);
    check({8'h0, channel_results[1]}, 32'h00900000);
    check({8'h0, channel_results[2]}, 32'h00600000);
    tick();
    check({31'h0, data_ready_output}, 32'h0);
    rd(ardc_pkg::ARDC_REG_RESULT1, rdat);
    check(rdat, 32'h00900000);
    rd(ardc_pkg::ARDC_REG_RESULT2, rdat);
    check(rdat, 32'h00600000);
    // Results are read-only
    wr(ardc_pkg::ARDC_REG_RESULT0, 32'h00123456);
    rd(ardc_pkg::ARDC_REG_RESULT0, rdat);
    check(rdat, 32'h007fffff);
    // Many unread pulses since reset, so ready and overrun
    rd(ardc_pkg::ARDC_REG_STATUS, rdat);
    check(rdat, 32'h3);
    wait_pulse(2, n);
    repeat (3) tick();
    check({31'h0, irq}, 32'h0);
    rd(ardc_pkg::ARDC_REG_STATUS, rdat);
    check(rdat, 32'h1);
    rd(ardc_pkg::ARDC_REG_STATUS, rdat);
    check(rdat, 32'h0);
    wr(ardc_pkg::ARDC_REG_MASK, 32'h1);
    wait_pulse(2, n);
    repeat (3) tick();
    check({31'h0, irq}, 32'h1);
    rd(ardc_pkg::ARDC_REG_STATUS, rdat);
    check(rdat, 32'h1);
    repeat (2) tick();
    check({31'h0, irq}, 32'h0);
    // Two pulses unread raise overrun
    wait_pulse(2, n);
    wait_pulse(2, n);
    repeat (3) tick();
    rd(ardc_pkg::ARDC_REG_STATUS, rdat);
    check(rdat, 32'h3);
    give_verdict();
  end
endmodule : ardc_top_tb
